// *** rtl/fcs_defs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

`define FCS_OFF_CLKDIV     4'h0
`define FCS_OFF_SECURITY   4'h1
`define FCS_OFF_TEST_A     4'h2
`define FCS_OFF_CONFIG     4'h3
`define FCS_OFF_PROTECT    4'h4
`define FCS_OFF_STATUS     4'h5
`define FCS_OFF_COMMAND    4'h6
`define FCS_OFF_TEST_B     4'h7
`define FCS_OFF_ADDR_HI    4'h8
`define FCS_OFF_ADDR_LO    4'h9
`define FCS_OFF_DATA_HI    4'hA
`define FCS_OFF_DATA_LO    4'hB
`define FCS_OFF_TEST_C     4'hC
`define FCS_OFF_TEST_D     4'hD
`define FCS_OFF_TEST_E     4'hE
`define FCS_OFF_TEST_F     4'hF

`define FCS_LOADED_BIT     7
`define FCS_PRESCALE_BIT   6
`define FCS_KEY_WRITE_ACCESS_BIT     5
`define FCS_KEYEN_ENABLED  2'h2
`define FCS_SEC_UNSECURED  2'h2
`define FCS_PRESCALE_DIV   8
`define FCS_CFG_WMASK      8'hE0
`define FCS_ADDR_HI_WMASK  8'h7F
`define FCS_CMD_WMASK      8'h65
`define FCS_CONFIG_ADDR    16'hFF0F
`define FCS_KEY_ADDR       16'hFF00
`define FCS_KEY_BYTES      8
`define FCS_RESET_BYTE     8'h00
`define FCS_CFG_RESET      8'h00

`endif

// *** rtl/fcs_pkg.sv ***
// Types shared by the flash clock and security register bank
package fcs_pkg;
    typedef struct packed {
        logic        loaded;
        logic        prescale_by_eight;
        logic [5:0]  divider_field;
    } fcs_clkdiv_s;

    typedef struct packed {
        logic [1:0]  backdoor_enable_field;
        logic [3:0]  user_nonvolatile_flags;
        logic [1:0]  security_state_field;
    } fcs_security_s;

    typedef enum logic [2:0] {
        FCS_LOAD_IDLE = 3'b001,
        FCS_LOAD_BUSY = 3'b010,
        FCS_LOAD_DONE = 3'b100
    } fcs_load_e;
endpackage

// *** rtl/fcs_regs.sv ***
// Flash clock divider and security register bank behind an APB slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_defs.svh"

module fcs_regs
    import fcs_pkg::*;
#(
    parameter int KEY_BYTES = `FCS_KEY_BYTES
)
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          clk_en,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    output logic      [15:0]   nvm_addr,
    output logic               nvm_rd,
    input  wire logic [7:0]    nvm_data,
    input  wire logic          nvm_valid,
    input  wire logic          key_try,
    input  wire logic [63:0]   key_value,
    output logic               key_pass,
    output logic               key_write_access,
    output logic               unsecured,
    output logic               backdoor_enabled,
    output logic               flash_tick,
    output logic               load_done
);

    fcs_load_e       load_q;
    fcs_clkdiv_s     clkdiv_q;
    fcs_security_s   sec_q;
    logic [7:0]      config_q;
    logic [7:0]      protect_q;
    logic [7:0]      status_q;
    logic [7:0]      command_q;
    logic [7:0]      addr_hi_q;
    logic [7:0]      addr_lo_q;
    logic [7:0]      data_hi_q;
    logic [7:0]      data_lo_q;
    logic [7:0]      key_q [KEY_BYTES];
    logic [3:0]      load_idx_q;
    logic [2:0]      pre_cnt_q;
    logic [5:0]      div_cnt_q;
    logic            wr_acc;
    logic            reg_wr;
    logic [3:0]      reg_idx;
    logic            in_map;
    logic [7:0]      rd_byte;
    logic            pre_tick;
    logic [63:0]     key_flat;

    assign wr_acc  = clk_en & psel & penable & pwrite & pready;
    assign reg_wr  = wr_acc & in_map;
    assign reg_idx = paddr[5:2];
    assign in_map  = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);

    // One wait state: ready rises in the access phase, drops after it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pready <= 1'b0;
        else if (clk_en)
            pready <= psel & penable & ~pready;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pslverr <= 1'b0;
        else if (clk_en)
            pslverr <= psel & penable & ~pready & ~in_map;
    end

    // Reset-time load of the configuration field: key bytes then option byte
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            load_q     <= FCS_LOAD_IDLE;
            load_idx_q <= 4'h0;
        end
        else if (clk_en)
        begin
            case (load_q)
                FCS_LOAD_IDLE:
                    load_q <= FCS_LOAD_BUSY;
                FCS_LOAD_BUSY:
                    if (nvm_valid)
                    begin
                        if (load_idx_q == 4'(KEY_BYTES))
                            load_q <= FCS_LOAD_DONE;
                        else
                            load_idx_q <= load_idx_q + 4'h1;
                    end
                default:
                    load_q <= FCS_LOAD_DONE;
            endcase
        end
    end

    // Address KEY_BYTES means the security option byte
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            nvm_addr <= `FCS_KEY_ADDR;
            nvm_rd   <= 1'b0;
        end
        else if (clk_en)
        begin
            // Request drops for a cycle after each byte so the address moves
            nvm_rd <= (load_q == FCS_LOAD_BUSY) & ~nvm_valid;
            if (load_idx_q == 4'(KEY_BYTES))
                nvm_addr <= `FCS_CONFIG_ADDR;
            else
                nvm_addr <= `FCS_KEY_ADDR + {12'h000, load_idx_q};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            for (int i = 0; i < KEY_BYTES; i++)
                key_q[i] <= `FCS_RESET_BYTE;
        else if (clk_en && load_q == FCS_LOAD_BUSY && nvm_valid &&
                 load_idx_q < 4'(KEY_BYTES))
            key_q[load_idx_q[2:0]] <= nvm_data;
    end

    always_comb
    begin
        key_flat = 64'h0;
        for (int i = 0; i < KEY_BYTES; i++)
            key_flat[63 - 8 * i -: 8] = key_q[i];
    end

    // Security register: loaded at reset, never written by software
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sec_q <= fcs_security_s'(`FCS_RESET_BYTE);
        else if (clk_en)
        begin
            if (load_q == FCS_LOAD_BUSY && nvm_valid &&
                load_idx_q == 4'(KEY_BYTES))
                sec_q <= fcs_security_s'(nvm_data);
            else if (key_pass)
                sec_q.security_state_field <= `FCS_SEC_UNSECURED;
        end
    end

    // Unlock is a key match while key write access is armed
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            key_pass <= 1'b0;
        else if (clk_en)
            key_pass <= key_try & backdoor_enabled &
                        config_q[`FCS_KEY_WRITE_ACCESS_BIT] &
                        (key_value == key_flat);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            backdoor_enabled <= 1'b0;
            unsecured        <= 1'b0;
            load_done        <= 1'b0;
        end
        else if (clk_en)
        begin
            backdoor_enabled <= (sec_q.backdoor_enable_field ==
                                 `FCS_KEYEN_ENABLED);
            unsecured <= (sec_q.security_state_field ==
                          `FCS_SEC_UNSECURED);
            load_done <= (load_q == FCS_LOAD_DONE);
        end
    end

    // Divider: write once after reset; lock cleared only by reset
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            clkdiv_q <= fcs_clkdiv_s'(`FCS_RESET_BYTE);
        else if (clk_en && wr_acc && in_map &&
                 reg_idx == `FCS_OFF_CLKDIV && !clkdiv_q.loaded)
        begin
            clkdiv_q.prescale_by_eight <= pwdata[`FCS_PRESCALE_BIT];
            clkdiv_q.divider_field     <= pwdata[5:0];
            clkdiv_q.loaded            <= 1'b1;
        end
    end

    // Timing tick: optional /8 prescale, then divide by field plus one
    assign pre_tick = ~clkdiv_q.prescale_by_eight |
                      (pre_cnt_q == 3'(`FCS_PRESCALE_DIV - 1));

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            pre_cnt_q <= 3'h0;
        else if (clk_en && clkdiv_q.loaded)
            pre_cnt_q <= pre_cnt_q + 3'h1;
    end

    // Tick stays quiet until software loads the divider
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_q  <= 6'h00;
            flash_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            flash_tick <= 1'b0;
            if (clkdiv_q.loaded && pre_tick)
            begin
                if (div_cnt_q >= clkdiv_q.divider_field)
                begin
                    div_cnt_q  <= 6'h00;
                    flash_tick <= 1'b1;
                end
                else
                    div_cnt_q <= div_cnt_q + 6'h01;
            end
        end
    end

    // Key access bit only follows a write while the backdoor is enabled
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            config_q <= `FCS_CFG_RESET;
        else if (reg_wr && reg_idx == `FCS_OFF_CONFIG)
        begin
            config_q[7:6] <= pwdata[7:6];
            if (backdoor_enabled)
                config_q[`FCS_KEY_WRITE_ACCESS_BIT] <=
                    pwdata[`FCS_KEY_WRITE_ACCESS_BIT];
        end
    end

    // Storage only, status write-one-to-clear; the behaviour behind these lives in other blocks
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            protect_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_PROTECT)
            protect_q <= pwdata[7:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            status_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_STATUS)
            status_q <= status_q & ~pwdata[7:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            command_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_COMMAND)
            command_q <= pwdata[7:0] & `FCS_CMD_WMASK;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            addr_hi_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_ADDR_HI)
            addr_hi_q <= pwdata[7:0] & `FCS_ADDR_HI_WMASK;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            addr_lo_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_ADDR_LO)
            addr_lo_q <= pwdata[7:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            data_hi_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_DATA_HI)
            data_hi_q <= pwdata[7:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            data_lo_q <= `FCS_RESET_BYTE;
        else if (reg_wr && reg_idx == `FCS_OFF_DATA_LO)
            data_lo_q <= pwdata[7:0];
    end

    // Factory test offsets fall through and read zero; security and test writes dropped
    always_comb
    begin
        rd_byte = 8'h00;
        if (reg_idx == `FCS_OFF_CLKDIV)
            rd_byte = clkdiv_q;
        else if (reg_idx == `FCS_OFF_SECURITY)
            rd_byte = sec_q;
        else if (reg_idx == `FCS_OFF_CONFIG)
            rd_byte = config_q & `FCS_CFG_WMASK;
        else if (reg_idx == `FCS_OFF_PROTECT)
            rd_byte = protect_q;
        else if (reg_idx == `FCS_OFF_STATUS)
            rd_byte = status_q;
        else if (reg_idx == `FCS_OFF_COMMAND)
            rd_byte = command_q;
        else if (reg_idx == `FCS_OFF_ADDR_HI)
            rd_byte = addr_hi_q;
        else if (reg_idx == `FCS_OFF_ADDR_LO)
            rd_byte = addr_lo_q;
        else if (reg_idx == `FCS_OFF_DATA_HI)
            rd_byte = data_hi_q;
        else if (reg_idx == `FCS_OFF_DATA_LO)
            rd_byte = data_lo_q;
        else
            rd_byte = 8'h00;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && penable && !pready && !pwrite)
            prdata <= in_map ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            key_write_access <= 1'b0;
        else if (clk_en)
            key_write_access <= config_q[`FCS_KEY_WRITE_ACCESS_BIT];
    end

endmodule
`default_nettype wire

// *** test/fcs_regs_monitor.sv ***
// Port-level checker for the flash clock and security register bank
`timescale 1ns/10ps
`default_nettype none
module fcs_regs_monitor
    import fcs_pkg::*;
#(
    parameter int KEY_BYTES = 8
)
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] nvm_addr,
    input wire logic        nvm_rd,
    input wire logic        key_try,
    input wire logic        key_pass,
    input wire logic        key_write_access,
    input wire logic        unsecured,
    input wire logic        backdoor_enabled,
    input wire logic        load_done
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_setup;
        psel && !penable ##1 psel && penable && clk_en && !pready;
    endsequence
    property p_ready_wait;
        s_setup |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("answer not after one wait state");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready longer than one cycle");
    property p_err_map;
        pready |-> pslverr == (paddr >= 12'h040 || paddr[1:0] != 2'b00);
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error flag does not match address");
    property p_rd_bytes;
        pready && !pwrite |-> prdata[31:8] == 24'h0
            && (!pslverr || prdata[7:0] == 8'h00);
    endproperty
    a_rd_bytes: assert property (p_rd_bytes)
        else $error("read data outside byte lane");
    property p_test_zero;
        pready && !pwrite && paddr inside {12'h008, 12'h01C, 12'h030,
            12'h034, 12'h038, 12'h03C} |-> prdata == 32'h0;
    endproperty
    a_test_zero: assert property (p_test_zero)
        else $error("factory test register not zero");
    property p_key_gate;
        key_pass |-> $past(key_try) && $past(key_write_access)
            && $past(backdoor_enabled);
    endproperty
    a_key_gate: assert property (p_key_gate)
        else $error("key pass without armed attempt");
    property p_unsec;
        key_pass |-> ##[1:2] unsecured;
    endproperty
    a_unsec: assert property (p_unsec)
        else $error("unlock did not unsecure");
    property p_kwa_gate;
        $rose(key_write_access) |-> backdoor_enabled;
    endproperty
    a_kwa_gate: assert property (p_kwa_gate)
        else $error("key access set while backdoor disabled");
    property p_nvm_range;
        nvm_rd |-> nvm_addr[15:4] == 12'hFF0
            && (!nvm_addr[3] || nvm_addr[3:0] == 4'hF);
    endproperty
    a_nvm_range: assert property (p_nvm_range)
        else $error("load reads outside configuration field");
    property p_done_hold;
        load_done |=> load_done;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("load done dropped");
endmodule
`default_nettype wire

// *** test/fcs_regs_tb_top.sv ***
// Directed bench for the flash clock and security register bank
`timescale 1ns/10ps
`default_nettype none
module fcs_regs_tb_top
    import fcs_pkg::*;
;
    localparam logic [63:0] KEY = 64'h1F2E_3D4C_5B6A_7988;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  nvm_data = 8'h00;
    logic        nvm_valid = 1'b0;
    logic        key_try = 1'b0;
    logic [63:0] key_value = 64'h0;
    logic [7:0]  sec_byte = 8'h00;
    logic [31:0] prdata, r;
    logic [15:0] nvm_addr;
    logic        pready, pslverr, nvm_rd, key_pass, key_write_access, e;
    logic        unsecured, backdoor_enabled, flash_tick, load_done;
    int          n_fail = 0;
    int          checks = 0;
    int          p;
    logic [7:0]  codes [4] = '{8'h00, 8'h41, 8'h82, 8'hFF};
    logic [3:0]  tests [6] = '{4'h2, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};

    always #2.5 mclk = ~mclk;

    fcs_regs i_dut (.mclk, .rst, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .nvm_addr, .nvm_rd, .nvm_data,
        .nvm_valid, .key_try, .key_value, .key_pass, .key_write_access,
        .unsecured, .backdoor_enabled, .flash_tick, .load_done);

    // Flash answers one byte per request; idle data toggles to stay honest
    always @(posedge mclk)
    begin
        nvm_valid <= nvm_rd === 1'b1 && !nvm_valid;
        if (nvm_rd === 1'b1 && !nvm_valid)
            nvm_data <= (nvm_addr[3:0] == 4'hF) ? sec_byte
                : KEY[8 * (7 - nvm_addr[2:0]) +: 8];
        else
            nvm_data <= ~nvm_data;
    end

    task wrap_up;
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] x);
        checks++;
        if (got !== x)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, x, got);
        end
    endtask

    // One wait state expected, but the wait is bounded rather than assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            n_fail++;
            wrap_up();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task wr(input logic [3:0] o, input logic [7:0] d);
        apb(1'b1, {6'h0, o, 2'b00}, {24'h0, d});
    endtask

    task rd(input logic [3:0] o, input logic [7:0] x);
        apb(1'b0, {6'h0, o, 2'b00}, 32'h0);
        chk($sformatf("reg %h", o), r, {24'h0, x});
    endtask

    task do_reset(input logic [7:0] b);
        int n;
        sec_byte <= b;
        rst      <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        n = 0;
        while (load_done !== 1'b1 && n < 300)
        begin
            @(posedge mclk);
            n++;
        end
        chk("load_done", 32'(load_done), 1);
        if (load_done !== 1'b1)
            wrap_up();
    endtask

    // First pass only finds a tick; the second measures the period
    task tick_per;
        int n;
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(posedge mclk);
                n++;
            end
            while (flash_tick !== 1'b1 && n < 1000);
            if (n >= 1000)
            begin
                n_fail++;
                wrap_up();
            end
        end
        p = n;
    endtask

    task try_key(input logic [63:0] k, input logic x);
        key_try   <= 1'b1;
        key_value <= k;
        @(posedge mclk);
        key_try   <= 1'b0;
        key_value <= ~k;
        @(posedge mclk);
        chk("key_pass", 32'(key_pass), 32'(x));
    endtask

    initial
    begin
        foreach (codes[i])
        begin
            do_reset(codes[i]);
            rd(4'h1, codes[i]);
            chk("keyen", 32'(backdoor_enabled),
                32'(codes[i][7:6] == 2'b10));
            chk("sec", 32'(unsecured), 32'(codes[i][1:0] == 2'b10));
        end
        do_reset(8'hB5);
        wr(4'h1, 8'hFF);
        rd(4'h1, 8'hB5);
        foreach (tests[i])
        begin
            wr(tests[i], 8'hFF);
            rd(tests[i], 8'h00);
        end
        wr(4'hA, 8'h5A);
        rd(4'hA, 8'h5A);
        apb(1'b0, 12'h040, 32'h0);
        chk("err hi", 32'(e), 1);
        apb(1'b0, 12'h005, 32'h0);
        chk("err odd", 32'(e), 1);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'hC3);
        rd(4'h0, 8'hC3);
        wr(4'h0, 8'h05);
        rd(4'h0, 8'hC3);
        tick_per();
        chk("tick /8", p, 32);
        wr(4'h3, 8'h20);
        @(posedge mclk);
        chk("kwa", 32'(key_write_access), 1);
        try_key(KEY ^ 64'h1, 1'b0);
        try_key(KEY, 1'b1);
        repeat (2) @(posedge mclk);
        chk("unsec", 32'(unsecured), 1);
        rd(4'h1, 8'hB6);
        do_reset(8'h41);
        rd(4'h0, 8'h00);
        wr(4'h0, 8'h02);
        rd(4'h0, 8'h82);
        tick_per();
        chk("tick /1", p, 3);
        wr(4'h3, 8'h20);
        rd(4'h3, 8'h00);
        try_key(KEY, 1'b0);
        wrap_up();
    end
endmodule

bind fcs_regs fcs_regs_monitor #(.KEY_BYTES(KEY_BYTES)) u_mon (.mclk, .rst,
    .clk_en, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .nvm_addr, .nvm_rd, .key_try, .key_pass, .key_write_access, .unsecured,
    .backdoor_enabled, .load_done);
`default_nettype wire
